// file: verilog/sccm_pkg.sv
`default_nettype none
package sccm_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] SCCM_OFF_SYS_CLK = 2'h0;
  localparam logic [1:0] SCCM_OFF_FAST_RC = 2'h1;
  localparam logic [1:0] SCCM_OFF_FAST_XTAL = 2'h2;
  localparam logic [1:0] SCCM_OFF_SLOW_XTAL = 2'h3;
  localparam int SCCM_ADDR_W = 2;
  localparam int SCCM_DATA_W = 8;

  // System clock control field positions
  localparam int SCCM_SEL_LSB = 5;
  localparam int SCCM_SEL_MSB = 7;
  localparam int SCCM_HSRC_BIT = 3;
  localparam int SCCM_LSRC_BIT = 2;
  localparam int SCCM_HHALT_BIT = 1;
  localparam int SCCM_LHALT_BIT = 0;
  // Oscillator control field positions
  localparam int SCCM_RC_CODE_LSB = 2;
  localparam int SCCM_RC_CODE_MSB = 3;
  localparam int SCCM_MODE_BIT = 2;
  localparam int SCCM_FLAG_BIT = 1;
  localparam int SCCM_EN_BIT = 0;

  // Clock select codes
  localparam logic [2:0] SCCM_SEL_LOW = 3'h7;

  // Reset values
  localparam logic [2:0] SCCM_SEL_RST = 3'h0;
  localparam logic [1:0] SCCM_RC_CODE_RST = 2'h0;
  localparam logic SCCM_RC_EN_RST = 1'b1;

  // Timing counts
  localparam int SCCM_SWITCH_SYS_TICKS = 4;
  localparam int SCCM_SETTLE_TICKS = 8;

  typedef struct packed {
    logic [2:0] sel;
    logic high_source_select;
    logic low_source_select;
    logic halt_high_osc_enable;
    logic halt_low_osc_enable;
  } sccm_sys_clk_s;

  typedef enum logic [5:0] {
    SCCM_MODE_FAST = 6'h01,
    SCCM_MODE_SLOW = 6'h02,
    SCCM_MODE_SLEEP = 6'h04,
    SCCM_MODE_IDLE_LOW_ONLY = 6'h08,
    SCCM_MODE_IDLE_BOTH_CLOCKS = 6'h10,
    SCCM_MODE_IDLE_HIGH_ONLY = 6'h20
  } sccm_mode_e;
endpackage
`default_nettype wire

// file: verilog/sccm_top.sv
// Chosen here: strobed register access and the register addresses.
`default_nettype none
module sccm_settle #(
  parameter int TICKS = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic tick_in,
  output logic stable_out
);
  localparam int CW = $clog2(TICKS + 1);
  logic [CW-1:0] cnt_r;

  // Restart wins over settling: the flag must read low first
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      stable_out <= 1'b0;
    end else if (ce_in) begin
      if (!run_in || restart_in) begin
        cnt_r <= '0;
        stable_out <= 1'b0;
      end else if (tick_in && !stable_out) begin
        if (cnt_r == CW'(TICKS - 1)) begin
          stable_out <= 1'b1;
        end
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// Operation
// - Select code picks divided high or low clock
// - High source bit picks fast RC or crystal
// - Low source bit picks slow RC or crystal
// - Halt with both bits low enters sleep
// - Sleep keeps slow RC only with watchdog
// - Halt low-only enable enters idle, high off
// - Halt with both bits high keeps all clocks
// - Halt high-only enable enters idle, low off
// - Slow mode keeps high oscillator per enable
// - Halt enable bits matter only while halted
// - Switch completes after four current system ticks
// - Two-bit code picks 4, 8, 12, 4 MHz
// - Fast RC flag clears then sets when settled
// - New fast RC frequency applied after stable
// - Fast RC runs per enable, resets to one
// - Unused system control bit four reads zero
// - Fast crystal flag clears then sets on enable
// - Speed-up bit locked while system control register selects slow crystal
module sccm_top
  import sccm_pkg::*;
#(
  parameter int SETTLE_TICKS = SCCM_SETTLE_TICKS
) (
  // Clock, reset, enable
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // Register port
  input wire logic [SCCM_ADDR_W-1:0] ADDR_IN,
  input wire logic [SCCM_DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [SCCM_DATA_W-1:0] RDATA_OUT,
  // Oscillator ticks, one cycle each
  input wire logic INTERNAL_FAST_RC_OSC_TICK_IN,
  input wire logic HXT_TICK_IN,
  input wire logic INTERNAL_SLOW_RC_OSC_TICK_IN,
  input wire logic LXT_TICK_IN,
  // Processor events
  input wire logic HALT_IN,
  input wire logic WAKE_IN,
  input wire logic WDT_EN_IN,
  // Oscillator controls
  output logic INTERNAL_FAST_RC_OSC_RUN_OUT,
  output logic [1:0] INTERNAL_FAST_RC_OSC_FREQ_OUT,
  output logic HXT_RUN_OUT,
  output logic HXT_DRIVE_OUT,
  output logic INTERNAL_SLOW_RC_OSC_RUN_OUT,
  output logic LXT_RUN_OUT,
  output logic LXT_SPEEDUP_OUT,
  // Clock enables and mode
  output logic SYS_TICK_OUT,
  output logic FH_TICK_OUT,
  output logic FSUB_TICK_OUT,
  output logic CPU_RUN_OUT,
  output logic [5:0] MODE_OUT
);
  sccm_sys_clk_s scc_r;
  sccm_sys_clk_s act_r;
  sccm_mode_e mode_r;
  logic [1:0] rc_code_r;
  logic rc_en_r;
  logic xt_drive_r;
  logic xt_en_r;
  logic lx_speed_r;
  logic lx_en_r;
  logic [5:0] div_cnt_r;
  logic [2:0] sw_cnt_r;
  logic rc_stable;
  logic xt_stable;
  logic lx_stable;

  logic halted;
  logic sleeping;
  logic fh_on;
  logic fsub_on;
  logic sys_on;
  logic fh_tick;
  logic fsub_tick;
  logic cur_tick;
  logic tgt_tick;
  logic pending;
  logic rc_restart;
  logic lx_locked;
  logic [5:0] div_mask;
  logic wr_scc;
  logic wr_rc;
  logic wr_xt;
  logic wr_lx;

  assign wr_scc = CE_IN && WR_IN && ADDR_IN == SCCM_OFF_SYS_CLK;
  assign wr_rc = CE_IN && WR_IN && ADDR_IN == SCCM_OFF_FAST_RC;
  assign wr_xt = CE_IN && WR_IN && ADDR_IN == SCCM_OFF_FAST_XTAL;
  assign wr_lx = CE_IN && WR_IN && ADDR_IN == SCCM_OFF_SLOW_XTAL;

  assign halted = !(mode_r == SCCM_MODE_FAST || mode_r == SCCM_MODE_SLOW);
  assign sleeping = mode_r == SCCM_MODE_SLEEP;
  // Halt enables only steer the clocks once the processor is off
  assign fh_on = halted ? scc_r.halt_high_osc_enable : 1'b1;
  assign fsub_on = halted ? scc_r.halt_low_osc_enable : 1'b1;
  // Idle keeps the system clock only if its source stays on
  assign sys_on = !halted ? 1'b1 : (act_r.sel == SCCM_SEL_LOW) ?
                  scc_r.halt_low_osc_enable : scc_r.halt_high_osc_enable;

  assign fh_tick = fh_on && (act_r.high_source_select ?
                   (HXT_TICK_IN && HXT_RUN_OUT) : (INTERNAL_FAST_RC_OSC_TICK_IN && INTERNAL_FAST_RC_OSC_RUN_OUT));
  assign fsub_tick = fsub_on && (act_r.low_source_select ?
                     (LXT_TICK_IN && LXT_RUN_OUT) : (INTERNAL_SLOW_RC_OSC_TICK_IN && INTERNAL_SLOW_RC_OSC_RUN_OUT));
  assign div_mask = 6'(({6'h00, 1'b1} << act_r.sel) - 7'h01);
  assign cur_tick = (act_r.sel == SCCM_SEL_LOW) ? fsub_tick :
                    (fh_tick && (div_cnt_r & div_mask) == div_mask);

  // Target edge comes from the requested source before it is live
  assign tgt_tick = (scc_r.sel == SCCM_SEL_LOW) ?
                    (scc_r.low_source_select ? (LXT_TICK_IN && LXT_RUN_OUT)
                                             : (INTERNAL_SLOW_RC_OSC_TICK_IN && INTERNAL_SLOW_RC_OSC_RUN_OUT)) :
                    (scc_r.high_source_select ? (HXT_TICK_IN && HXT_RUN_OUT)
                                              : (INTERNAL_FAST_RC_OSC_TICK_IN && INTERNAL_FAST_RC_OSC_RUN_OUT));
  assign pending = {scc_r.sel, scc_r.high_source_select, scc_r.low_source_select} !=
                   {act_r.sel, act_r.high_source_select, act_r.low_source_select};
  assign rc_restart = wr_rc && WDATA_IN[SCCM_RC_CODE_MSB:SCCM_RC_CODE_LSB] != rc_code_r;
  assign lx_locked = scc_r.sel == SCCM_SEL_LOW && scc_r.low_source_select;

  // Register writes
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      scc_r <= '{SCCM_SEL_RST, 1'b0, 1'b0, 1'b0, 1'b0};
      rc_code_r <= SCCM_RC_CODE_RST;
      rc_en_r <= SCCM_RC_EN_RST;
      xt_drive_r <= 1'b0;
      xt_en_r <= 1'b0;
      lx_speed_r <= 1'b0;
      lx_en_r <= 1'b0;
    end else begin
      if (wr_scc) begin
        scc_r.sel <= WDATA_IN[SCCM_SEL_MSB:SCCM_SEL_LSB];
        scc_r.high_source_select <= WDATA_IN[SCCM_HSRC_BIT];
        scc_r.low_source_select <= WDATA_IN[SCCM_LSRC_BIT];
        scc_r.halt_high_osc_enable <= WDATA_IN[SCCM_HHALT_BIT];
        scc_r.halt_low_osc_enable <= WDATA_IN[SCCM_LHALT_BIT];
      end
      if (wr_rc) begin
        rc_code_r <= WDATA_IN[SCCM_RC_CODE_MSB:SCCM_RC_CODE_LSB];
        rc_en_r <= WDATA_IN[SCCM_EN_BIT];
      end
      if (wr_xt) begin
        // Drive strength is frozen while the crystal enable bit is set
        if (!xt_en_r) begin
          xt_drive_r <= WDATA_IN[SCCM_MODE_BIT];
        end
        xt_en_r <= WDATA_IN[SCCM_EN_BIT];
      end
      if (wr_lx) begin
        if (!lx_locked) begin
          lx_speed_r <= WDATA_IN[SCCM_MODE_BIT];
        end
        lx_en_r <= WDATA_IN[SCCM_EN_BIT];
      end
    end
  end

  // Oscillator run controls
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      INTERNAL_FAST_RC_OSC_RUN_OUT <= 1'b0;
      HXT_RUN_OUT <= 1'b0;
      LXT_RUN_OUT <= 1'b0;
      INTERNAL_SLOW_RC_OSC_RUN_OUT <= 1'b0;
      HXT_DRIVE_OUT <= 1'b0;
      LXT_SPEEDUP_OUT <= 1'b0;
    end else if (CE_IN) begin
      INTERNAL_FAST_RC_OSC_RUN_OUT <= rc_en_r && fh_on;
      HXT_RUN_OUT <= xt_en_r && fh_on;
      LXT_RUN_OUT <= lx_en_r && fsub_on;
      INTERNAL_SLOW_RC_OSC_RUN_OUT <= !sleeping || WDT_EN_IN;
      HXT_DRIVE_OUT <= xt_drive_r;
      LXT_SPEEDUP_OUT <= lx_speed_r;
    end
  end

  sccm_settle #(.TICKS(SETTLE_TICKS)) u_rc_settle (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .run_in(INTERNAL_FAST_RC_OSC_RUN_OUT),
    .restart_in(rc_restart),
    .tick_in(INTERNAL_FAST_RC_OSC_TICK_IN),
    .stable_out(rc_stable)
  );

  sccm_settle #(.TICKS(SETTLE_TICKS)) u_xt_settle (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .run_in(HXT_RUN_OUT),
    .restart_in(1'b0),
    .tick_in(HXT_TICK_IN),
    .stable_out(xt_stable)
  );

  sccm_settle #(.TICKS(SETTLE_TICKS)) u_lx_settle (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .run_in(LXT_RUN_OUT),
    .restart_in(1'b0),
    .tick_in(LXT_TICK_IN),
    .stable_out(lx_stable)
  );

  // Code 11 falls back to the 4 MHz setting downstream
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      INTERNAL_FAST_RC_OSC_FREQ_OUT <= SCCM_RC_CODE_RST;
    end else if (CE_IN && rc_stable) begin
      INTERNAL_FAST_RC_OSC_FREQ_OUT <= rc_code_r;
    end
  end

  // Divider and glitch-free source switch; a dead current source stalls it
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      div_cnt_r <= 6'h00;
      sw_cnt_r <= 3'h0;
      act_r <= '{SCCM_SEL_RST, 1'b0, 1'b0, 1'b0, 1'b0};
    end else if (CE_IN) begin
      if (fh_tick) begin
        div_cnt_r <= div_cnt_r + 6'h01;
      end
      if (!pending || halted) begin
        sw_cnt_r <= 3'h0;
      end else if (sw_cnt_r < 3'(SCCM_SWITCH_SYS_TICKS)) begin
        if (cur_tick) begin
          sw_cnt_r <= sw_cnt_r + 3'h1;
        end
      end else if (tgt_tick) begin
        act_r <= scc_r;
        sw_cnt_r <= 3'h0;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      SYS_TICK_OUT <= 1'b0;
      FH_TICK_OUT <= 1'b0;
      FSUB_TICK_OUT <= 1'b0;
    end else if (CE_IN) begin
      SYS_TICK_OUT <= cur_tick && sys_on;
      FH_TICK_OUT <= fh_tick;
      FSUB_TICK_OUT <= fsub_tick;
    end
  end

  // Power mode sequencer
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      mode_r <= SCCM_MODE_FAST;
    end else if (CE_IN) begin
      case (mode_r)
        SCCM_MODE_FAST, SCCM_MODE_SLOW: begin
          if (HALT_IN) begin
            case ({scc_r.halt_high_osc_enable, scc_r.halt_low_osc_enable})
              2'h0: mode_r <= SCCM_MODE_SLEEP;
              2'h1: mode_r <= SCCM_MODE_IDLE_LOW_ONLY;
              2'h3: mode_r <= SCCM_MODE_IDLE_BOTH_CLOCKS;
              default: mode_r <= SCCM_MODE_IDLE_HIGH_ONLY;
            endcase
          end else begin
            mode_r <= (act_r.sel == SCCM_SEL_LOW) ? SCCM_MODE_SLOW : SCCM_MODE_FAST;
          end
        end
        SCCM_MODE_SLEEP, SCCM_MODE_IDLE_LOW_ONLY, SCCM_MODE_IDLE_BOTH_CLOCKS,
        SCCM_MODE_IDLE_HIGH_ONLY: begin
          if (WAKE_IN) begin
            mode_r <= (act_r.sel == SCCM_SEL_LOW) ? SCCM_MODE_SLOW : SCCM_MODE_FAST;
          end
        end
        default: mode_r <= SCCM_MODE_FAST;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      CPU_RUN_OUT <= 1'b0;
      MODE_OUT <= 6'h00;
    end else if (CE_IN) begin
      CPU_RUN_OUT <= !halted;
      MODE_OUT <= mode_r;
    end
  end

  // Read data stands one cycle after the strobe, zero after other enabled cycles, held while CE_IN is low
  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (CE_IN && RD_IN) begin
      case (ADDR_IN)
        SCCM_OFF_SYS_CLK: RDATA_OUT <= {scc_r.sel, 1'b0, scc_r.high_source_select,
                                        scc_r.low_source_select,
                                        scc_r.halt_high_osc_enable,
                                        scc_r.halt_low_osc_enable};
        SCCM_OFF_FAST_RC: RDATA_OUT <= {4'h0, rc_code_r, rc_stable, rc_en_r};
        SCCM_OFF_FAST_XTAL: RDATA_OUT <= {5'h00, xt_drive_r, xt_stable, xt_en_r};
        SCCM_OFF_SLOW_XTAL: RDATA_OUT <= {5'h00, lx_speed_r, lx_stable, lx_en_r};
        default: RDATA_OUT <= 8'h00;
      endcase
    end else if (CE_IN) begin
      RDATA_OUT <= 8'h00;
    end
  end

  property p_slow_sel;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && !halted && act_r.sel == SCCM_SEL_LOW && fsub_tick |=> SYS_TICK_OUT;
  endproperty
  a_slow_sel: assert property (p_slow_sel) else $error("low clock tick lost");

  property p_high_rc;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && fh_on && !act_r.high_source_select && INTERNAL_FAST_RC_OSC_TICK_IN && INTERNAL_FAST_RC_OSC_RUN_OUT
      |=> FH_TICK_OUT;
  endproperty
  a_high_rc: assert property (p_high_rc) else $error("fast RC tick lost");

  property p_low_rc;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && fsub_on && !act_r.low_source_select && INTERNAL_SLOW_RC_OSC_TICK_IN && INTERNAL_SLOW_RC_OSC_RUN_OUT
      |=> FSUB_TICK_OUT;
  endproperty
  a_low_rc: assert property (p_low_rc) else $error("slow RC tick lost");

  property p_sleep_off;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && sleeping |=> !SYS_TICK_OUT && !FH_TICK_OUT && !FSUB_TICK_OUT && !CPU_RUN_OUT;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("clock alive in sleep");

  property p_sleep_wdt;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && sleeping && !WDT_EN_IN |=> !INTERNAL_SLOW_RC_OSC_RUN_OUT;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("slow RC on without watchdog");

  property p_idle_low;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && mode_r == SCCM_MODE_IDLE_LOW_ONLY |=> !FH_TICK_OUT;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("high clock on in idle low");

  property p_idle_high;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && mode_r == SCCM_MODE_IDLE_HIGH_ONLY |=> !FSUB_TICK_OUT;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("low clock on in idle high");

  property p_rc_restart;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      rc_restart |=> !rc_stable ##1 !rc_stable;
  endproperty
  a_rc_restart: assert property (p_rc_restart) else $error("RC flag not cleared");

  property p_rc_apply;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && !rc_stable |=> INTERNAL_FAST_RC_OSC_FREQ_OUT == $past(INTERNAL_FAST_RC_OSC_FREQ_OUT);
  endproperty
  a_rc_apply: assert property (p_rc_apply) else $error("RC code applied early");

  property p_lx_lock;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      wr_lx && lx_locked |=> $stable(lx_speed_r);
  endproperty
  a_lx_lock: assert property (p_lx_lock) else $error("speed-up changed while locked");

  property p_bit4;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && RD_IN && ADDR_IN == SCCM_OFF_SYS_CLK |=> RDATA_OUT[4] == 1'b0;
  endproperty
  a_bit4: assert property (p_bit4) else $error("unused bit reads one");

  property p_switch_wait;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      CE_IN && sw_cnt_r < 3'(SCCM_SWITCH_SYS_TICKS) |=> act_r == $past(act_r);
  endproperty
  a_switch_wait: assert property (p_switch_wait) else $error("switched too early");

  c_sleep: cover property (@(posedge MCLK_IN) mode_r == SCCM_MODE_SLEEP);
  c_idle_both: cover property (@(posedge MCLK_IN) mode_r == SCCM_MODE_IDLE_BOTH_CLOCKS);
  c_switch: cover property (@(posedge MCLK_IN) pending ##1 !pending);
  c_rc_stable: cover property (@(posedge MCLK_IN) rc_restart ##[1:200] rc_stable);
endmodule
`default_nettype wire

// file: dv/testbench.sv
`default_nettype none
module testbench import sccm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK_IN = 1'b0, RST_N_IN = 1'b0, CE_IN = 1'b1;
  logic [1:0] ADDR_IN = 2'h0;
  logic [7:0] WDATA_IN = 8'h00, RDATA_OUT;
  logic WR_IN = 1'b0, RD_IN = 1'b0, HALT_IN = 1'b0, WAKE_IN = 1'b0, WDT_EN_IN = 1'b0;
  logic INTERNAL_FAST_RC_OSC_TICK_IN = 1'b0, HXT_TICK_IN = 1'b0, INTERNAL_SLOW_RC_OSC_TICK_IN = 1'b0, LXT_TICK_IN = 1'b0;
  logic INTERNAL_FAST_RC_OSC_RUN_OUT, HXT_RUN_OUT, HXT_DRIVE_OUT, INTERNAL_SLOW_RC_OSC_RUN_OUT, LXT_RUN_OUT, LXT_SPEEDUP_OUT;
  logic [1:0] INTERNAL_FAST_RC_OSC_FREQ_OUT;
  logic SYS_TICK_OUT, FH_TICK_OUT, FSUB_TICK_OUT, CPU_RUN_OUT;
  logic [5:0] MODE_OUT;
  logic internal_fast_rc_osc_go = 1'b0, hxt_go = 1'b0, internal_slow_rc_osc_go = 1'b0, lxt_go = 1'b0;
  logic [15:0] cyc = 16'h0000;
  logic [7:0] regm [4] = '{8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] wmask [4] = '{8'hef, 8'h0d, 8'h05, 8'h05};
  int err_count = 0, n_checks = 0, seed = 32'h60a02537, k, f, s, y;

  sccm_top #(.SETTLE_TICKS(2)) sccm_top_inst (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
    .CE_IN(CE_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .INTERNAL_FAST_RC_OSC_TICK_IN(INTERNAL_FAST_RC_OSC_TICK_IN), .HXT_TICK_IN(HXT_TICK_IN),
    .INTERNAL_SLOW_RC_OSC_TICK_IN(INTERNAL_SLOW_RC_OSC_TICK_IN), .LXT_TICK_IN(LXT_TICK_IN), .HALT_IN(HALT_IN),
    .WAKE_IN(WAKE_IN), .WDT_EN_IN(WDT_EN_IN), .INTERNAL_FAST_RC_OSC_RUN_OUT(INTERNAL_FAST_RC_OSC_RUN_OUT),
    .INTERNAL_FAST_RC_OSC_FREQ_OUT(INTERNAL_FAST_RC_OSC_FREQ_OUT), .HXT_RUN_OUT(HXT_RUN_OUT), .HXT_DRIVE_OUT(HXT_DRIVE_OUT),
    .INTERNAL_SLOW_RC_OSC_RUN_OUT(INTERNAL_SLOW_RC_OSC_RUN_OUT), .LXT_RUN_OUT(LXT_RUN_OUT), .LXT_SPEEDUP_OUT(LXT_SPEEDUP_OUT),
    .SYS_TICK_OUT(SYS_TICK_OUT), .FH_TICK_OUT(FH_TICK_OUT), .FSUB_TICK_OUT(FSUB_TICK_OUT),
    .CPU_RUN_OUT(CPU_RUN_OUT), .MODE_OUT(MODE_OUT));

  always #50 MCLK_IN = ~MCLK_IN;

  // Fixed tick spacing so the divided system rate is exact over a window
  always @(posedge MCLK_IN) begin
    cyc <= cyc + 16'h0001;
    INTERNAL_FAST_RC_OSC_TICK_IN <= internal_fast_rc_osc_go;
    HXT_TICK_IN <= hxt_go && cyc[0];
    INTERNAL_SLOW_RC_OSC_TICK_IN <= internal_slow_rc_osc_go && (cyc[1:0] == 2'h0);
    LXT_TICK_IN <= lxt_go && (cyc[2:0] == 3'h0);
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      err_count++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  // Model keeps writable bits only; locked bits keep their old value
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = wmask[a];
    if (a == 2'h2 && regm[2][0]) m[2] = 1'b0;
    if (a == 2'h3 && regm[0][7:5] == SCCM_SEL_LOW && regm[0][2]) m[2] = 1'b0;
    regm[a] = (regm[a] & ~m) | (d & m);
    @(posedge MCLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1'b1;
    @(posedge MCLK_IN);
    WR_IN <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic fl);
    logic [7:0] e;
    e = regm[a] | ((a != 2'h0) ? {6'h00, fl, 1'b0} : 8'h00);
    @(posedge MCLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    @(posedge MCLK_IN);
    RD_IN <= 1'b0;
    #1;
    chk(RDATA_OUT === e, "read data");
  endtask

  task automatic cnt(input int n);
    f = 0;
    s = 0;
    y = 0;
    repeat (n) begin
      @(posedge MCLK_IN);
      #1;
      f += int'(FH_TICK_OUT === 1'b1);
      y += int'(FSUB_TICK_OUT === 1'b1);
      s += int'(SYS_TICK_OUT === 1'b1);
    end
  endtask

  task automatic rate(input int e);
    cnt(256);
    chk(s >= e - 1 && s <= e + 1, "system tick rate");
  endtask

  task automatic pulse(input bit h);
    @(posedge MCLK_IN);
    if (h) HALT_IN <= 1'b1; else WAKE_IN <= 1'b1;
    @(posedge MCLK_IN);
    HALT_IN <= 1'b0;
    WAKE_IN <= 1'b0;
    repeat (4) @(posedge MCLK_IN);
    #1;
  endtask

  function automatic logic [5:0] halt_mode(input int hb);
    case (hb)
      0: return SCCM_MODE_SLEEP;
      1: return SCCM_MODE_IDLE_LOW_ONLY;
      3: return SCCM_MODE_IDLE_BOTH_CLOCKS;
      default: return SCCM_MODE_IDLE_HIGH_ONLY;
    endcase
  endfunction

  initial begin
    repeat (30000) @(posedge MCLK_IN);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge MCLK_IN);
    RST_N_IN <= 1'b1;
    repeat (2) @(posedge MCLK_IN);
    #1;
    chk(MODE_OUT === SCCM_MODE_FAST && CPU_RUN_OUT === 1'b1, "run mode");
    chk(INTERNAL_FAST_RC_OSC_RUN_OUT === 1'b1, "fast rc run");
    for (int a = 0; a < 4; a++) rd(2'(a), 1'b0);
    wr(2'h0, 8'h10);
    rd(2'h0, 1'b0);
    internal_fast_rc_osc_go = 1'b1;
    internal_slow_rc_osc_go = 1'b1;
    repeat (8) @(posedge MCLK_IN);
    rd(2'h1, 1'b1);
    // Code change: flag drops, output keeps old code until settled
    for (int c = 1; c < 5; c++) begin
      internal_fast_rc_osc_go = 1'b0;
      wr(2'h1, {4'h0, 2'(c), 2'h1});
      repeat (2) @(posedge MCLK_IN);
      rd(2'h1, 1'b0);
      chk(INTERNAL_FAST_RC_OSC_FREQ_OUT === 2'(c - 1), "freq applied early");
      internal_fast_rc_osc_go = 1'b1;
      repeat (8) @(posedge MCLK_IN);
      rd(2'h1, 1'b1);
      chk(INTERNAL_FAST_RC_OSC_FREQ_OUT === 2'(c), "freq code");
    end
    for (int sel = 0; sel < 7; sel++) begin
      wr(2'h0, {3'(sel), 5'h00});
      repeat (400) @(posedge MCLK_IN);
      rate(256 >> sel);
      chk(MODE_OUT === SCCM_MODE_FAST, "fast mode");
    end
    wr(2'h0, 8'he0);
    k = 0;
    while (MODE_OUT !== SCCM_MODE_SLOW && k < 400) begin
      @(posedge MCLK_IN);
      #1;
      k++;
    end
    chk(k >= 192 && k <= 360, "switch delay");
    rate(64);
    hxt_go = 1'b0;
    wr(2'h3, 8'h05);
    lxt_go <= 1'b1;
    wr(2'h0, 8'he4);
    repeat (400) @(posedge MCLK_IN);
    rate(32);
    wr(2'h3, 8'h01);
    rd(2'h3, 1'b1);
    chk(LXT_SPEEDUP_OUT === 1'b1 && LXT_RUN_OUT === 1'b1, "speed-up locked");
    wr(2'h2, 8'h05);
    rd(2'h2, 1'b0);
    hxt_go = 1'b1;
    repeat (10) @(posedge MCLK_IN);
    wr(2'h2, 8'h01);
    rd(2'h2, 1'b1);
    chk(HXT_DRIVE_OUT === 1'b1 && HXT_RUN_OUT === 1'b1, "drive locked");
    wr(2'h0, 8'h08);
    repeat (400) @(posedge MCLK_IN);
    rate(128);
    wr(2'h1, 8'h00);
    repeat (2) @(posedge MCLK_IN);
    #1;
    chk(INTERNAL_FAST_RC_OSC_RUN_OUT === 1'b0, "fast rc stop");
    wr(2'h0, 8'he8);
    repeat (400) @(posedge MCLK_IN);
    cnt(64);
    chk(f > 0 && HXT_RUN_OUT === 1'b1, "high kept in slow");
    wr(2'h2, 8'h00);
    repeat (4) @(posedge MCLK_IN);
    cnt(64);
    chk(f == 0 && HXT_RUN_OUT === 1'b0, "high stopped in slow");
    wr(2'h1, 8'h01);
    repeat (8) @(posedge MCLK_IN);
    // Halt bits in every combination, low and undivided high system clock
    for (int sl = 7; sl >= 0; sl -= 7) begin
      wr(2'h0, {3'(sl), 5'h00});
      repeat (400) @(posedge MCLK_IN);
      for (int hb = 0; hb < 4; hb++) begin
        @(posedge MCLK_IN);
        WDT_EN_IN <= 1'($random(seed));
        wr(2'h0, {3'(sl), 3'h0, 2'(hb)});
        rd(2'h0, 1'b0);
        chk(MODE_OUT === ((sl == 7) ? SCCM_MODE_SLOW : SCCM_MODE_FAST), "run ignores");
        pulse(1'b1);
        chk(MODE_OUT === halt_mode(hb) && CPU_RUN_OUT === 1'b0, "halt mode");
        cnt(64);
        chk((f > 0) == (hb >= 2), "high clock in halt");
        chk((y > 0) == (hb % 2 == 1), "low clock in halt");
        chk((s > 0) == (hb == 3 || (hb == 1 && sl == 7) || (hb == 2 && sl == 0)),
            "system clock in halt");
        if (hb == 0) chk(INTERNAL_SLOW_RC_OSC_RUN_OUT === WDT_EN_IN, "slow rc in sleep");
        pulse(1'b0);
        chk(CPU_RUN_OUT === 1'b1, "wake");
      end
    end
    // Clock enable low: a write and a halt must both be ignored
    @(posedge MCLK_IN);
    CE_IN <= 1'b0;
    ADDR_IN <= 2'h0;
    WDATA_IN <= 8'he3;
    WR_IN <= 1'b1;
    HALT_IN <= 1'b1;
    @(posedge MCLK_IN);
    WR_IN <= 1'b0;
    HALT_IN <= 1'b0;
    repeat (4) @(posedge MCLK_IN);
    CE_IN <= 1'b1;
    rd(2'h0, 1'b0);
    chk(CPU_RUN_OUT === 1'b1 && MODE_OUT === SCCM_MODE_FAST, "clock enable freeze");
    // Second reset in mid-run, fast RC ticks keep running through it
    @(posedge MCLK_IN);
    RST_N_IN <= 1'b0;
    repeat (3) @(posedge MCLK_IN);
    RST_N_IN <= 1'b1;
    regm = '{8'h00, 8'h01, 8'h00, 8'h00};
    repeat (2) @(posedge MCLK_IN);
    #1;
    chk(MODE_OUT === SCCM_MODE_FAST && CPU_RUN_OUT === 1'b1, "run mode again");
    for (int a = 0; a < 4; a++) rd(2'(a), 1'(a == 1));
    tally_and_finish();
  end
endmodule
`default_nettype wire
